// ---- logic/cfg_space_regs.svh ----
// constants of the two-function configuration space: offsets, fields, values
// assumes inclusion by the single configuration space module
`ifndef CFG_SPACE_REGS_SVH
`define CFG_SPACE_REGS_SVH

// address phase fields
`define CFG_FUNC_MSB 10
`define CFG_FUNC_LSB 8
`define CFG_REG_MSB 7
`define CFG_REG_LSB 2
`define CFG_TYPE0 2'h0
`define CFG_NUM_FUNC 3'h2
`define CFG_NUM_REGS 6'h10

// register byte offsets
`define OFF_IDENT 8'h00
`define OFF_STATCMD 8'h04
`define OFF_CLASSREV 8'h08
`define OFF_HDRTYPE 8'h0C
`define OFF_WINBASE 8'h10
`define OFF_INTROUTE 8'h3C

// command half: writable bits 9, 8, 6, 2, 1
`define CMD_WR_MASK 16'h0346
`define CMD_SERR_OFF 8
`define CMD_PAR_RESP 6
`define CMD_MASTER 2
`define CMD_MEM 1

// status half, bits counted from 0 within the half (word bit is 16 higher)
`define ST_DET_PAR 15
`define ST_SIG_SERR 14
`define ST_RX_MABORT 13
`define ST_RX_TABORT 12
`define ST_DATA_PAR 8
`define ST_FIXED 16'h0280
`define ST_66MHZ 16'h0020
`define ST_RR_MASK 16'hF100

// fixed codes and pin assignment
`define CLASS_F0 24'h028000
`define INT_PIN_F0 8'h01
`define INT_PIN_F1 8'h02
`define LAT_MASK 32'h0000FF00
`define LAT_MSB 15
`define LAT_LSB 8
`define LINE_MASK 32'h000000FF
`define BYTE_ZERO 8'h00

`endif

// ---- logic/cfg_space_pkg.sv ----
// types for the two-function configuration space
// assumes cfg_space_regs.svh supplies the numeric constants
package cfg_space_pkg;

    // one configuration access as seen in its address and data phase
    typedef struct packed {
        logic idsel;
        logic write;
        logic [31:0] ad;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } cfg_req_type;

    // bus events reported by the protocol logic, one set per function
    typedef struct packed {
        logic tgt_parity;
        logic serr_driven;
        logic master_abort;
        logic target_abort;
        logic perr_as_master;
    } bus_event_type;

endpackage : cfg_space_pkg

// ---- logic/cfg_space.sv ----
// configuration space of a two-function bus agent, with interrupt pins
// assumes one access request per cycle at most, synchronous to i_mclk
`timescale 1ns/100ps
`include "cfg_space_regs.svh"

module cfg_space
    import cfg_space_pkg::*;
#(
    // arbitrary identity values, not any real assignment
    parameter logic [11:0] DEV_ID_BASE = 12'hA5C,
    parameter logic [3:0] CHAN_VARIANT = 4'h8,
    parameter logic [15:0] VENDOR_ID = 16'h5A5A,
    parameter logic [7:0] REVISION_ID = 8'h01,
    parameter logic [23:0] CLASS_F1 = 24'h068000,
    parameter logic [7:0] HDR_TYPE_F0 = 8'h80,
    parameter logic [7:0] HDR_TYPE_F1 = 8'h00,
    parameter logic [15:0] GNT_LAT_F0 = 16'h0000,
    parameter bit CAP_66MHZ = 1'b1,
    parameter int WIN_F0_BITS = 20,
    parameter int WIN_F1_BITS = 20
)
(
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire cfg_req_type i_req,
    input wire logic i_req_valid,
    input wire bus_event_type [1:0] i_evt,
    input wire logic i_hdlc_irq_n,
    input wire logic i_expansion_interrupt_in_n,
    output logic o_claim,
    output logic [31:0] o_rdata,
    output logic [1:0] o_mem_enable,
    output logic o_master_enable,
    output logic [1:0] o_par_resp,
    output logic [1:0] o_serr_disable,
    output logic o_inta_n,
    output logic o_intb_n
);

    if (WIN_F0_BITS < 4 || WIN_F0_BITS > 31 ||
        WIN_F1_BITS < 4 || WIN_F1_BITS > 31)
    begin : g_bad_window
        $error("window size bits out of range 4..31");
    end

    localparam logic [31:0] WIN_MASK_F0 = ~((32'h1 << WIN_F0_BITS) - 32'h1);
    localparam logic [31:0] WIN_MASK_F1 = ~((32'h1 << WIN_F1_BITS) - 32'h1);
    localparam logic [15:0] STATUS_FIXED =
        `ST_FIXED | (CAP_66MHZ ? `ST_66MHZ : 16'h0000);
    localparam logic [15:0] RR_MASK = `ST_RR_MASK;

    logic [15:0] cmd [2];
    logic [15:0] stat [2];
    logic [31:0] win_base [2];
    logic [7:0] int_line [2];
    logic [7:0] lat_timer;

    // address phase decode
    wire [2:0] func = i_req.ad[`CFG_FUNC_MSB:`CFG_FUNC_LSB];
    wire [5:0] reg_idx = i_req.ad[`CFG_REG_MSB:`CFG_REG_LSB];
    wire [7:0] offset = {reg_idx, 2'h0};
    wire f1 = func[0];
    wire type0 = i_req.ad[1:0] == `CFG_TYPE0;
    wire hit = i_req_valid && i_req.idsel && type0 && func < `CFG_NUM_FUNC;
    wire in_hdr = reg_idx < `CFG_NUM_REGS;
    wire wr = hit && i_req.write && in_hdr;
    wire [31:0] be_mask = {{8{i_req.byte_en[3]}}, {8{i_req.byte_en[2]}},
                           {8{i_req.byte_en[1]}}, {8{i_req.byte_en[0]}}};

    wire [31:0] ident = {DEV_ID_BASE, CHAN_VARIANT, VENDOR_ID};
    wire [31:0] classrev = {f1 ? CLASS_F1 : `CLASS_F0, REVISION_ID};
    wire [31:0] hdrtype = f1 ? {`BYTE_ZERO, HDR_TYPE_F1, 16'h0000}
                             : {`BYTE_ZERO, HDR_TYPE_F0, lat_timer, `BYTE_ZERO};
    wire [31:0] introute = f1 ? {16'h0000, `INT_PIN_F1, int_line[1]}
                              : {GNT_LAT_F0, `INT_PIN_F0, int_line[0]};
    // medium decode timing and fixed status bits
    wire [31:0] statcmd = {stat[f1] | STATUS_FIXED, cmd[f1]};
    wire [31:0] rd_word =
        !in_hdr ? 32'h0 :
        offset == `OFF_IDENT ? ident :
        offset == `OFF_STATCMD ? statcmd :
        offset == `OFF_CLASSREV ? classrev :
        offset == `OFF_HDRTYPE ? hdrtype :
        offset == `OFF_WINBASE ? win_base[f1] :
        offset == `OFF_INTROUTE ? introute :
        32'h0;

    // writable masks per register, byte enables folded in
    wire [31:0] cmd_m = {16'h0000, `CMD_WR_MASK} & be_mask;
    wire [31:0] rr_clr = {RR_MASK, 16'h0000} & be_mask & i_req.wdata;
    wire [31:0] lat_m = `LAT_MASK & be_mask;
    wire [31:0] line_m = `LINE_MASK & be_mask;

    // claim one clock after the request
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_claim <= 1'b0;
            o_rdata <= 32'h0;
        end
        else
        begin
            o_claim <= hit;
            o_rdata <= (hit && !i_req.write) ? rd_word : 32'h0;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            lat_timer <= `BYTE_ZERO;
        end
        else if (wr && !f1 && offset == `OFF_HDRTYPE)
        begin
            lat_timer <= (lat_timer & ~lat_m[`LAT_MSB:`LAT_LSB]) |
                         (i_req.wdata[`LAT_MSB:`LAT_LSB] &
                          lat_m[`LAT_MSB:`LAT_LSB]);
        end
    end

    for (genvar f = 0; f < 2; f++)
    begin : g_func
        wire sel = wr && (f1 == (f == 1));
        wire [31:0] win_m = (f == 0 ? WIN_MASK_F0 : WIN_MASK_F1) & be_mask;
        wire [15:0] clr = (sel && offset == `OFF_STATCMD) ?
                          rr_clr[31:16] : 16'h0000;
        logic [15:0] set;
        always_comb
        begin
            set = 16'h0000;
            set[`ST_DET_PAR] = i_evt[f].tgt_parity;
            set[`ST_SIG_SERR] = i_evt[f].serr_driven;
            set[`ST_RX_MABORT] = i_evt[f].master_abort;
            set[`ST_RX_TABORT] = i_evt[f].target_abort;
            set[`ST_DATA_PAR] = i_evt[f].perr_as_master &&
                                cmd[f][`CMD_PAR_RESP];
        end

        always_ff @(posedge i_mclk)
        begin
            if (i_srst)
            begin
                cmd[f] <= 16'h0000;
                stat[f] <= 16'h0000;
                win_base[f] <= 32'h0;
                int_line[f] <= `BYTE_ZERO;
            end
            else
            begin
                stat[f] <= (stat[f] & ~clr) | set;
                if (sel && offset == `OFF_STATCMD)
                begin
                    cmd[f] <= 16'((({16'h0000, cmd[f]} & ~cmd_m) |
                                   (i_req.wdata & cmd_m)));
                end
                if (sel && offset == `OFF_WINBASE)
                begin
                    win_base[f] <= (win_base[f] & ~win_m) |
                                   (i_req.wdata & win_m);
                end
                if (sel && offset == `OFF_INTROUTE)
                begin
                    int_line[f] <= 8'((({24'h0, int_line[f]} & ~line_m) |
                                      (i_req.wdata & line_m)));
                end
            end
        end
        assign o_mem_enable[f] = cmd[f][`CMD_MEM];
        assign o_par_resp[f] = cmd[f][`CMD_PAR_RESP];
        assign o_serr_disable[f] = cmd[f][`CMD_SERR_OFF];
    end

    // master enable of the controller function
    assign o_master_enable = cmd[0][`CMD_MASTER];

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_inta_n <= 1'b1;
            o_intb_n <= 1'b1;
        end
        else
        begin
            o_inta_n <= i_hdlc_irq_n;
            o_intb_n <= i_expansion_interrupt_in_n;
        end
    end

    // assertions
    wire rd_hit = hit && !i_req.write;

    property p_claim_hit;
        @(posedge i_mclk) disable iff (i_srst)
        hit |=> o_claim;
    endproperty
    a_claim_hit: assert property (p_claim_hit)
        else $error("access not claimed next clock");

    property p_bad_func;
        @(posedge i_mclk) disable iff (i_srst)
        (i_req_valid && func >= `CFG_NUM_FUNC) |=> !o_claim;
    endproperty
    a_bad_func: assert property (p_bad_func)
        else $error("claimed an absent function");

    property p_no_type1;
        @(posedge i_mclk) disable iff (i_srst)
        (i_req_valid && (i_req.ad[1:0] != `CFG_TYPE0 || !i_req.idsel))
            |=> !o_claim;
    endproperty
    a_no_type1: assert property (p_no_type1)
        else $error("claimed type 1 or unselected cycle");

    property p_beyond_zero;
        @(posedge i_mclk) disable iff (i_srst)
        (rd_hit && !in_hdr) |=> o_rdata == 32'h0;
    endproperty
    a_beyond_zero: assert property (p_beyond_zero)
        else $error("device-dependent region read nonzero");

    property p_ident_shared;
        @(posedge i_mclk) disable iff (i_srst)
        (rd_hit && offset == `OFF_IDENT)
            |=> o_rdata == {DEV_ID_BASE, CHAN_VARIANT, VENDOR_ID};
    endproperty
    a_ident_shared: assert property (p_ident_shared)
        else $error("identity word differs");

    property p_par_sets;
        @(posedge i_mclk) disable iff (i_srst)
        i_evt[0].tgt_parity |=> stat[0][`ST_DET_PAR] ##1
            (stat[0][`ST_DET_PAR] || $past(g_func[0].clr[`ST_DET_PAR]));
    endproperty
    a_par_sets: assert property (p_par_sets)
        else $error("target parity flag not set");

    property p_rr_keep;
        @(posedge i_mclk) disable iff (i_srst)
        (wr && !f1 && offset == `OFF_STATCMD && i_req.wdata[31:16] == 16'h0)
            |=> stat[0] == ($past(stat[0]) | $past(g_func[0].set));
    endproperty
    a_rr_keep: assert property (p_rr_keep)
        else $error("zero write disturbed a flag");

    property p_data_par_gate;
        @(posedge i_mclk) disable iff (i_srst)
        (!stat[0][`ST_DATA_PAR] && !cmd[0][`CMD_PAR_RESP])
            |=> !stat[0][`ST_DATA_PAR];
    endproperty
    a_data_par_gate: assert property (p_data_par_gate)
        else $error("data parity flag set with response off");

    property p_reset_clear;
        @(posedge i_mclk)
        i_srst |=> cmd[0] == 16'h0 && cmd[1] == 16'h0 &&
                   !o_master_enable && o_mem_enable == 2'b00;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("writable bits not cleared by reset");

    property p_int_pins;
        @(posedge i_mclk) disable iff (i_srst)
        ##1 o_intb_n == $past(i_expansion_interrupt_in_n) &&
            o_inta_n == $past(i_hdlc_irq_n);
    endproperty
    a_int_pins: assert property (p_int_pins)
        else $error("interrupt pin mismatch");

endmodule : cfg_space

// ---- verif/cfg_host_model.sv ----
// far-side host model issuing configuration cycles, good and refused
// assumes the bench calls cfg_access, one access at a time
`timescale 1ns/100ps
module cfg_host_model
    import cfg_space_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_claim,
    input wire logic [31:0] i_rdata,
    output cfg_req_type o_req,
    output logic o_req_valid
);
    initial
    begin
        o_req = '0;
        o_req_valid = 1'b0;
    end

    // caller picks function, idsel and low address bits
    task automatic cfg_access(input cfg_req_type r, output logic claim,
        output logic [31:0] rdata);
        @(posedge i_mclk);
        o_req <= r;
        o_req_valid <= 1'b1;
        @(posedge i_mclk);
        o_req_valid <= 1'b0;
        // released lines carry junk so a stale value is never trusted
        o_req <= ~r;
        @(negedge i_mclk);
        claim = i_claim;
        rdata = i_rdata;
    endtask : cfg_access
endmodule : cfg_host_model

// ---- verif/pci_two_function_config_space_tb.sv ----
// self-checking bench for the two-function configuration space
// assumes the host model drives the request side of the dut
`timescale 1ns/100ps
module pci_two_function_config_space_tb;
    import cfg_space_pkg::*;
    typedef struct packed {
        logic [2:0] fn;
        logic [5:0] rg;
        logic wr;
        logic [3:0] be;
        logic [31:0] wd;
        logic idsel;
        logic [1:0] low;
        logic claim;
        logic [31:0] rd;
    } row_type;
    localparam row_type rows [21] = '{
        '{3'h0, 6'h00, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b1, 32'hA5C85A5A},
        '{3'h1, 6'h00, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b1, 32'hA5C85A5A},
        '{3'h0, 6'h01, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b1, 32'h02A00000},
        '{3'h0, 6'h01, 1'b1, 4'hF, 32'hFFFFFFFF, 1'b1, 2'h0, 1'b1, 32'h0},
        '{3'h0, 6'h01, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b1, 32'h02A00346},
        '{3'h1, 6'h01, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b1, 32'h02A00000},
        '{3'h0, 6'h02, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b1, 32'h02800001},
        '{3'h1, 6'h02, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b1, 32'h06800001},
        '{3'h0, 6'h03, 1'b1, 4'hF, 32'hFFFFFFFF, 1'b1, 2'h0, 1'b1, 32'h0},
        '{3'h0, 6'h03, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b1, 32'h0080FF00},
        '{3'h1, 6'h03, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b1, 32'h0},
        '{3'h0, 6'h04, 1'b1, 4'hF, 32'hFFFFFFFF, 1'b1, 2'h0, 1'b1, 32'h0},
        '{3'h0, 6'h04, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b1, 32'hFFF00000},
        '{3'h0, 6'h05, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b1, 32'h0},
        '{3'h0, 6'h14, 1'b1, 4'hF, 32'hFFFFFFFF, 1'b1, 2'h0, 1'b1, 32'h0},
        '{3'h0, 6'h14, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b1, 32'h0},
        '{3'h1, 6'h0F, 1'b1, 4'h1, 32'hFFFFFFFF, 1'b1, 2'h0, 1'b1, 32'h0},
        '{3'h1, 6'h0F, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b1, 32'h000002FF},
        '{3'h0, 6'h0F, 1'b1, 4'h0, 32'hFFFFFFFF, 1'b1, 2'h0, 1'b1, 32'h0},
        '{3'h0, 6'h0F, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b1, 32'h00000100},
        '{3'h2, 6'h00, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b0, 32'h0}
    };
    logic i_mclk = 1'b0;
    logic i_srst = 1'b1;
    cfg_req_type i_req;
    logic i_req_valid;
    bus_event_type [1:0] i_evt = '0;
    logic i_hdlc_irq_n = 1'b1;
    logic i_expansion_interrupt_in_n = 1'b1;
    logic o_claim;
    logic [31:0] o_rdata;
    logic [1:0] o_mem_enable;
    logic o_master_enable;
    logic [1:0] o_par_resp;
    logic [1:0] o_serr_disable;
    logic o_inta_n;
    logic o_intb_n;
    int miscompares = 0;
    int compares = 0;
    logic c;
    logic [31:0] d;

    always #12.5 i_mclk = ~i_mclk;

    cfg_space dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_req(i_req),
        .i_req_valid(i_req_valid), .i_evt(i_evt),
        .i_hdlc_irq_n(i_hdlc_irq_n),
        .i_expansion_interrupt_in_n(i_expansion_interrupt_in_n),
        .o_claim(o_claim), .o_rdata(o_rdata), .o_mem_enable(o_mem_enable),
        .o_master_enable(o_master_enable), .o_par_resp(o_par_resp),
        .o_serr_disable(o_serr_disable), .o_inta_n(o_inta_n),
        .o_intb_n(o_intb_n));

    cfg_host_model host (.i_mclk(i_mclk), .i_claim(o_claim),
        .i_rdata(o_rdata), .o_req(i_req), .o_req_valid(i_req_valid));

    task automatic chk(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic acc(input row_type r);
        cfg_req_type q;
        q = '{1'b1, r.wr, {21'h0, r.fn, r.rg, r.low}, r.be, r.wd};
        q.idsel = r.idsel;
        host.cfg_access(q, c, d);
        chk("claim", {31'h0, r.claim}, {31'h0, c});
        chk("rdata", r.rd, d);
    endtask : acc

    task automatic wr(input logic [2:0] f, input logic [5:0] g,
        input logic [31:0] v);
        acc('{f, g, 1'b1, 4'hF, v, 1'b1, 2'h0, 1'b1, 32'h0});
    endtask : wr

    task automatic rd(input logic [2:0] f, input logic [5:0] g,
        input logic [31:0] e);
        acc('{f, g, 1'b0, 4'hF, 32'h0, 1'b1, 2'h0, 1'b1, e});
    endtask : rd

    task automatic pulse(input bus_event_type [1:0] e);
        @(posedge i_mclk);
        i_evt <= e;
        @(posedge i_mclk);
        i_evt <= '0;
    endtask : pulse

    task automatic test_done;
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    initial
    begin
        #200000;
        miscompares++;
        test_done();
    end

    initial
    begin
        repeat (12) @(posedge i_mclk);
        i_srst <= 1'b0;
        @(posedge i_mclk);
        foreach (rows[i])
            acc(rows[i]);
        acc('{3'h0, 6'h0, 1'b0, 4'hF, 32'h0, 1'b0, 2'h0, 1'b0, 32'h0});
        acc('{3'h0, 6'h0, 1'b0, 4'hF, 32'h0, 1'b1, 2'h1, 1'b0, 32'h0});
        chk("enables", 32'h2B, {25'h0, o_serr_disable, o_par_resp,
            o_mem_enable, o_master_enable});
        wr(3'h0, 6'h01, 32'h0);
        // all events with parity response off: bit 24 must stay clear
        pulse(10'h01F);
        rd(3'h0, 6'h01, 32'hF2A00000);
        rd(3'h1, 6'h01, 32'h02A00000);
        // function 1 flags are its own
        pulse(10'h200);
        rd(3'h1, 6'h01, 32'h82A00000);
        wr(3'h0, 6'h01, 32'h00000040);
        pulse(10'h001);
        rd(3'h0, 6'h01, 32'hF3A00040);
        wr(3'h0, 6'h01, 32'h40000040);
        rd(3'h0, 6'h01, 32'hB3A00040);
        @(posedge i_mclk);
        i_hdlc_irq_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        chk("int pins", 32'h1, {30'h0, o_inta_n, o_intb_n});
        @(posedge i_mclk);
        i_hdlc_irq_n <= 1'b1;
        i_expansion_interrupt_in_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        chk("int pins", 32'h2, {30'h0, o_inta_n, o_intb_n});
        @(posedge i_mclk);
        i_expansion_interrupt_in_n <= 1'b1;
        wr(3'h1, 6'h01, 32'h00000002);
        @(posedge i_mclk);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_srst <= 1'b0;
        @(negedge i_mclk);
        chk("ctl", 32'h0, {25'h0, o_serr_disable, o_mem_enable,
            o_master_enable, o_par_resp});
        rd(3'h0, 6'h01, 32'h02A00000);
        rd(3'h0, 6'h03, 32'h00800000);
        rd(3'h0, 6'h04, 32'h0);
        rd(3'h1, 6'h0F, 32'h00000200);
        test_done();
    end
endmodule : pci_two_function_config_space_tb
